// ===== rtl/asc_pkg.sv
// Purpose: shared constants for the converter sequencer block
// Assumes: 25 MHz system clock, AXI4-Lite register access
// Notes:   register offsets are byte addresses of aligned words
package asc_pkg;
  // register byte offsets
  localparam logic [4:0] ASC_OFF_CTRL  = 5'h00;
  localparam logic [4:0] ASC_OFF_CLK   = 5'h04;
  localparam logic [4:0] ASC_OFF_IRQ   = 5'h08;
  localparam logic [4:0] ASC_OFF_RESLO = 5'h0C;
  localparam logic [4:0] ASC_OFF_RESHI = 5'h10;
  localparam logic [4:0] ASC_OFF_DIR   = 5'h14;
  // control register fields
  localparam int ASC_CTRL_CH_LSB  = 0;
  localparam int ASC_CTRL_PIN_LSB = 3;
  localparam int ASC_CTRL_START   = 6;
  localparam int ASC_CTRL_BUSY    = 7;
  localparam int ASC_CTRL_PWROFF  = 8;
  // interrupt register fields
  localparam int ASC_IRQ_FLAG = 0;
  localparam int ASC_IRQ_EN   = 1;
  localparam int ASC_IRQ_GEN  = 2;
  // reset values
  localparam logic [2:0] ASC_RST_CH   = 3'h0;
  localparam logic [2:0] ASC_RST_PIN  = 3'h0;
  localparam logic [1:0] ASC_RST_DIV  = 2'h0;
  localparam logic [3:0] ASC_RST_DIR  = 4'hF;
  localparam logic       ASC_RST_BUSY = 1'b1;
  // divider codes and ratios
  localparam logic [1:0] ASC_DIV_2_CODE  = 2'h0;
  localparam logic [1:0] ASC_DIV_8_CODE  = 2'h1;
  localparam logic [1:0] ASC_DIV_32_CODE = 2'h2;
  localparam logic [4:0] ASC_DIV_2_LAST  = 5'h01;
  localparam logic [4:0] ASC_DIV_8_LAST  = 5'h07;
  localparam logic [4:0] ASC_DIV_32_LAST = 5'h1F;
  // conversion length in converter clock periods
  localparam logic [3:0] ASC_CONV_TICKS  = 4'hD;
  localparam logic [2:0] ASC_PIN_ALL     = 3'h4;
  // sequencer states
  typedef enum logic [2:0] {
    ASC_IDLE = 3'b001,
    ASC_HOLD = 3'b010,
    ASC_CONV = 3'b100
  } asc_state_t;
endpackage

// ===== rtl/asc_clk_div.sv
// Purpose: converter clock tick generator
// Assumes: clear restarts the period so counts align with conversion
// Notes:   reserved code produces no ticks, so a conversion stalls
module asc_clk_div
  import asc_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_b,
  // control
  input  wire logic       clr,
  input  wire logic [1:0] div_sel,
  // one-cycle tick per converter period
  output logic            tick
);
  logic [4:0] cnt;       // position within period
  logic [4:0] next_cnt;  // next position
  logic [4:0] last;      // final count for ratio
  logic       valid_sel; // code is defined

  // ratio lookup
  always_comb begin
    valid_sel = 1'b1;
    unique case (div_sel)
      ASC_DIV_2_CODE:  last = ASC_DIV_2_LAST;
      ASC_DIV_8_CODE:  last = ASC_DIV_8_LAST;
      ASC_DIV_32_CODE: last = ASC_DIV_32_LAST;
      default: begin
        last      = ASC_DIV_32_LAST;
        valid_sel = 1'b0;
      end
    endcase
    tick     = valid_sel && (cnt == last) && !clr;
    next_cnt = (clr || tick || !valid_sel) ? 5'h00 : cnt + 5'h01;
  end

  // period counter
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt <= 5'h00;
    end else begin
      cnt <= next_cnt;
    end
  end
endmodule

// ===== rtl/asc_top.sv
// Purpose: converter channel, pin and conversion sequencing control
// Assumes: AXI4-Lite master, analog front end outside this block
// Notes:   registers answer one cycle after a request is complete
module asc_top
  import asc_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // axi4-lite write address and data
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [4:0]  s_axi_awaddr,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  // axi4-lite write response
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic [1:0]       s_axi_bresp,
  // axi4-lite read
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [4:0]  s_axi_araddr,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  // analog converter core
  output logic [1:0]       analog_channel,
  output logic             converter_reset,
  output logic             converter_power_down,
  input  wire logic [8:0]  converter_data,
  // shared port pins
  input  wire logic [3:0]  pull_high_cfg,
  output logic [3:0]       analog_pin_en,
  output logic [3:0]       pull_high_en,
  output logic [3:0]       pin_input_mode,
  // interrupt request toward controller
  output logic             converter_irq
);
  // reset release through two flops
  logic rst_meta_b;
  logic rst_sync_b;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_b <= 1'b0;
      rst_sync_b <= 1'b0;
    end else begin
      rst_meta_b <= 1'b1;
      rst_sync_b <= rst_meta_b;
    end
  end

  // software state
  logic [2:0] channel_select;          // converter input pick
  logic [2:0] pin_config_select;       // analog pin set
  logic       start;                   // start bit
  logic       converter_power_off_bit; // extra power-off
  logic [1:0] clock_divide_sel;        // hi and lo divide bits
  logic [3:0] port_b_direction_reg;    // 1 = input
  logic       global_irq_enable;
  logic       converter_irq_enable;
  logic       irq_flag;                // sticky completion flag
  logic       conversion_busy_flag;
  logic [7:0] conversion_result_low;
  logic [7:0] conversion_result_high;
  logic [2:0] next_channel_select;
  logic [2:0] next_pin_config_select;
  logic       next_start;
  logic       next_power_off;
  logic [1:0] next_clock_divide_sel;
  logic [3:0] next_direction;
  logic       next_global_irq_enable;
  logic       next_converter_irq_enable;
  logic       next_irq_flag;
  logic       next_busy;
  logic [7:0] next_result_low;
  logic [7:0] next_result_high;

  // bus state
  logic        aw_full;     // address captured
  logic        w_full;      // data captured
  logic [4:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        next_aw_full;
  logic        next_w_full;
  logic [4:0]  next_aw_addr;
  logic [31:0] next_w_data;
  logic [3:0]  next_w_strb;
  logic        next_bvalid;
  logic [1:0]  next_bresp;
  logic        next_rvalid;
  logic [31:0] next_rdata;
  logic [1:0]  next_rresp;
  logic        wr_go;       // write performed this cycle
  logic        wr_hit;      // write address mapped

  // sequencer state
  asc_state_t state;
  asc_state_t next_state;
  logic [3:0] tick_cnt;
  logic [3:0] next_tick_cnt;
  logic       start_q;      // start seen last cycle
  logic       start_rise;
  logic       conv_tick;
  logic       conv_done;
  logic       powered_off;

  // write and read channel handshakes
  always_comb begin
    s_axi_awready = !aw_full;
    s_axi_wready  = !w_full;
    s_axi_arready = !s_axi_rvalid;
    next_aw_full  = aw_full;
    next_w_full   = w_full;
    next_aw_addr  = aw_addr;
    next_w_data   = w_data;
    next_w_strb   = w_strb;
    if (s_axi_awvalid && !aw_full) begin
      next_aw_full = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_full) begin
      next_w_full = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    // one write in flight: wait for the response to drain
    wr_go  = aw_full && w_full && !s_axi_bvalid;
    wr_hit = (aw_addr <= ASC_OFF_DIR) && (aw_addr[1:0] == 2'h0);
    next_bvalid = s_axi_bvalid && !s_axi_bready;
    next_bresp  = s_axi_bresp;
    if (wr_go) begin
      next_aw_full = 1'b0;
      next_w_full  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = wr_hit ? 2'b00 : 2'b10;
    end
    // read mux, unmapped answers slave error and zero
    next_rvalid = s_axi_rvalid && !s_axi_rready;
    next_rdata  = s_axi_rdata;
    next_rresp  = s_axi_rresp;
    if (s_axi_arvalid && !s_axi_rvalid) begin
      next_rvalid = 1'b1;
      next_rresp  = 2'b00;
      next_rdata  = 32'h0000_0000;
      unique case (s_axi_araddr)
        ASC_OFF_CTRL: begin
          next_rdata[ASC_CTRL_CH_LSB +: 3]  = channel_select;
          next_rdata[ASC_CTRL_PIN_LSB +: 3] = pin_config_select;
          next_rdata[ASC_CTRL_START]        = start;
          next_rdata[ASC_CTRL_BUSY]         = conversion_busy_flag;
          next_rdata[ASC_CTRL_PWROFF]       = converter_power_off_bit;
        end
        ASC_OFF_CLK:   next_rdata[1:0] = clock_divide_sel;
        ASC_OFF_IRQ: begin
          next_rdata[ASC_IRQ_FLAG] = irq_flag;
          next_rdata[ASC_IRQ_EN]   = converter_irq_enable;
          next_rdata[ASC_IRQ_GEN]  = global_irq_enable;
        end
        ASC_OFF_RESLO: next_rdata[7:0] = conversion_result_low;
        ASC_OFF_RESHI: next_rdata[7:0] = conversion_result_high;
        ASC_OFF_DIR:   next_rdata[3:0] = port_b_direction_reg;
        default:       next_rresp      = 2'b10;
      endcase
    end
  end

  // bus registers
  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      aw_full      <= 1'b0;
      w_full       <= 1'b0;
      aw_addr      <= 5'h00;
      w_data       <= 32'h0000_0000;
      w_strb       <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'b00;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= 2'b00;
    end else begin
      aw_full      <= next_aw_full;
      w_full       <= next_w_full;
      aw_addr      <= next_aw_addr;
      w_data       <= next_w_data;
      w_strb       <= next_w_strb;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp  <= next_bresp;
      s_axi_rvalid <= next_rvalid;
      s_axi_rdata  <= next_rdata;
      s_axi_rresp  <= next_rresp;
    end
  end

  // converter clock ticks restart on each conversion entry
  asc_clk_div u_div (
    .clk     (clk),
    .rst_b   (rst_sync_b),
    .clr     (state != ASC_CONV),
    .div_sel (clock_divide_sel),
    .tick    (conv_tick)
  );

  // sequencer next state
  always_comb begin
    start_rise    = start && !start_q;
    // zero pin code also powers down
    powered_off   = (pin_config_select == 3'h0) || converter_power_off_bit;
    next_state    = state;
    next_tick_cnt = tick_cnt;
    conv_done     = 1'b0;
    unique case (state)
      ASC_IDLE: begin
        if (start_rise && !powered_off) begin
          next_state = ASC_HOLD;
        end
      end
      // hold in reset while start high
      ASC_HOLD: begin
        if (powered_off) begin
          next_state = ASC_IDLE;
        end else if (!start) begin
          next_state    = ASC_CONV;
          next_tick_cnt = 4'h0;
        end
      end
      ASC_CONV: begin
        if (powered_off) begin
          next_state = ASC_IDLE;
        end else if (start_rise) begin
          next_state = ASC_HOLD;
        end else if (conv_tick) begin
          next_tick_cnt = tick_cnt + 4'h1;
          if (tick_cnt == ASC_CONV_TICKS - 4'h1) begin
            next_state = ASC_IDLE;
            conv_done  = 1'b1;
          end
        end
      end
    endcase
  end

  // sequencer registers
  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      state    <= ASC_IDLE;
      tick_cnt <= 4'h0;
      start_q  <= 1'b0;
    end else begin
      state    <= next_state;
      tick_cnt <= next_tick_cnt;
      start_q  <= start;
    end
  end

  // software register next values
  always_comb begin
    next_channel_select       = channel_select;
    next_pin_config_select    = pin_config_select;
    next_start                = start;
    next_power_off            = converter_power_off_bit;
    next_clock_divide_sel     = clock_divide_sel;
    next_direction            = port_b_direction_reg;
    next_global_irq_enable    = global_irq_enable;
    next_converter_irq_enable = converter_irq_enable;
    next_irq_flag             = irq_flag;
    next_busy                 = conversion_busy_flag;
    next_result_low           = conversion_result_low;
    next_result_high          = conversion_result_high;
    if (wr_go && w_strb[0]) begin
      unique case (aw_addr)
        ASC_OFF_CTRL: begin
          next_channel_select    = w_data[ASC_CTRL_CH_LSB +: 3];
          next_pin_config_select = w_data[ASC_CTRL_PIN_LSB +: 3];
          next_start             = w_data[ASC_CTRL_START];
        end
        ASC_OFF_CLK:  next_clock_divide_sel = w_data[1:0];
        ASC_OFF_IRQ: begin
          next_converter_irq_enable = w_data[ASC_IRQ_EN];
          next_global_irq_enable    = w_data[ASC_IRQ_GEN];
          // write one clears the flag
          next_irq_flag = irq_flag && !w_data[ASC_IRQ_FLAG];
        end
        ASC_OFF_DIR:  next_direction = w_data[3:0];
        default:      next_direction = port_b_direction_reg;
      endcase
    end
    if (wr_go && w_strb[1] && aw_addr == ASC_OFF_CTRL) begin
      next_power_off = w_data[ASC_CTRL_PWROFF];
    end
    // busy forced on by start rise
    if (start_rise || state == ASC_HOLD) begin
      next_busy = 1'b1;
    end
    // selection change keeps old busy, no recheck
    if (conv_done) begin
      next_busy     = 1'b0;
      next_irq_flag = 1'b1;
      next_result_high = converter_data[8:1];
      next_result_low  = {converter_data[0], 7'h00};
    end
  end

  // software registers
  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      channel_select          <= ASC_RST_CH;
      pin_config_select       <= ASC_RST_PIN;
      start                   <= 1'b0;
      converter_power_off_bit <= 1'b0;
      clock_divide_sel        <= ASC_RST_DIV;
      port_b_direction_reg    <= ASC_RST_DIR;
      global_irq_enable       <= 1'b0;
      converter_irq_enable    <= 1'b0;
      irq_flag                <= 1'b0;
      conversion_busy_flag    <= ASC_RST_BUSY;
      conversion_result_low   <= 8'h00;
      conversion_result_high  <= 8'h00;
    end else begin
      channel_select          <= next_channel_select;
      pin_config_select       <= next_pin_config_select;
      start                   <= next_start;
      converter_power_off_bit <= next_power_off;
      clock_divide_sel        <= next_clock_divide_sel;
      port_b_direction_reg    <= next_direction;
      global_irq_enable       <= next_global_irq_enable;
      converter_irq_enable    <= next_converter_irq_enable;
      irq_flag                <= next_irq_flag;
      conversion_busy_flag    <= next_busy;
      conversion_result_low   <= next_result_low;
      conversion_result_high  <= next_result_high;
    end
  end

  // pin and converter outputs
  always_comb begin
    // one of four inputs feeds the converter
    // top channel bit ignored by the mux
    analog_channel       = channel_select[1:0];
    converter_reset      = (state == ASC_HOLD);
    converter_power_down = powered_off;
    analog_pin_en = (pin_config_select >= ASC_PIN_ALL) ? 4'hF :
                    4'((5'h01 << pin_config_select) - 5'h01);
    pull_high_en   = pull_high_cfg & ~analog_pin_en;
    pin_input_mode = port_b_direction_reg | analog_pin_en;
    converter_irq  = irq_flag && global_irq_enable && converter_irq_enable;
  end

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_sync_b);

  sequence start_pulse_s;
    start_rise ##1 (state == ASC_HOLD);
  endsequence

  busy_on_start_a: assert property (
    start_pulse_s |-> conversion_busy_flag && converter_reset)
    else $error("busy or reset missing after start rise");
  hold_keeps_busy_a: assert property (
    (state == ASC_HOLD) |=> conversion_busy_flag)
    else $error("busy dropped while start held");
  done_clears_a: assert property (
    conv_done |=> !conversion_busy_flag && irq_flag)
    else $error("completion did not clear busy and set flag");
  irq_gate_a: assert property (
    converter_irq == (irq_flag && global_irq_enable
                      && converter_irq_enable))
    else $error("interrupt gating wrong");
  all_pins_a: assert property (
    (pin_config_select >= ASC_PIN_ALL) |-> analog_pin_en == 4'hF)
    else $error("pins not all analog");
  pins_off_a: assert property (
    (pin_config_select == 3'h0) |->
      analog_pin_en == 4'h0 && converter_power_down)
    else $error("zero code not plain and powered down");
  pull_off_a: assert property (
    (pull_high_en & analog_pin_en) == 4'h0)
    else $error("pull-high left on analog pin");
  dir_override_a: assert property (
    (pin_input_mode & analog_pin_en) == analog_pin_en)
    else $error("analog pin not forced to input");
  result_hold_a: assert property (
    !conv_done |=> $stable(conversion_result_high))
    else $error("result changed without completion");
  tick_count_a: assert property (
    conv_done |-> tick_cnt == ASC_CONV_TICKS - 4'h1 && conv_tick)
    else $error("completion not on thirteenth period");
  high_byte_a: assert property (
    conv_done |=> conversion_result_high == $past(converter_data[8:1]))
    else $error("high result byte misplaced");
  conv_start_a: assert property (
    (state == ASC_HOLD) && !start && !powered_off |=> state == ASC_CONV)
    else $error("start release did not begin conversion");
endmodule

// ===== test/asc_conv_model.sv
// Purpose: behavioural converter core facing the sequencer
// Assumes: one fixed sample per input, steady while converting
// Notes:   while held in reset or powered down the data toggles, so stale bits keep changing
module asc_conv_model (
  // clock
  input  wire logic       clk,
  // control from the sequencer
  input  wire logic [1:0] analog_channel,
  input  wire logic       converter_reset,
  input  wire logic       converter_power_down,
  // result toward the sequencer
  output logic [8:0]      converter_data
);
  timeunit 1ns;
  timeprecision 1ps;

  // one sample per analog input
  logic [8:0] sample [4];

  initial begin
    sample = '{9'h1A5, 9'h05A, 9'h1FF, 9'h100};
    converter_data = 9'h0AA;
  end

  always @(posedge clk) begin
    if (converter_reset || converter_power_down) begin
      // not converting: keep the line moving
      converter_data <= ~converter_data;
    end else begin
      converter_data <= sample[analog_channel];
    end
  end
endmodule

// ===== test/adc_sequencer_control_test.sv
// Purpose: self-checking bench for the converter sequencer
// Assumes: 25 MHz clock, axi4-lite master tasks, behavioural core
// Notes:   conversion length is timed on the interrupt line
module adc_sequencer_control_test
  import asc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // one conversion case: input, divider code, sample
  typedef struct packed {
    logic [1:0] ch;
    logic [1:0] div;
    logic [8:0] d;
  } asc_row_t;

  logic        clk, rst_b, awvalid, awready, wvalid, wready, bvalid;
  logic        bready, arvalid, arready, rvalid, rready, cres, cpd, irq;
  logic [4:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rdat;
  logic [3:0]  wstrb, phcfg, pin_en, ph_en, in_mode;
  logic [1:0]  bresp, rresp, brsp, rrsp, chan;
  logic [8:0]  cdata;
  int          error_cnt, compares, k;
  asc_row_t    rows [4];

  asc_top u_dut (
    .clk(clk), .rst_b(rst_b),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_bresp(bresp), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_araddr(araddr), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .analog_channel(chan), .converter_reset(cres),
    .converter_power_down(cpd), .converter_data(cdata),
    .pull_high_cfg(phcfg), .analog_pin_en(pin_en), .pull_high_en(ph_en),
    .pin_input_mode(in_mode), .converter_irq(irq)
  );

  asc_conv_model u_core (
    .clk(clk), .analog_channel(chan), .converter_reset(cres),
    .converter_power_down(cpd), .converter_data(cdata)
  );

  // free-running system clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic print_verdict();
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // a wait that ran out counts as a mismatch
  task automatic fail();
    error_cnt++;
    print_verdict();
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // write: address and data offered together, each dropped when taken
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic ta, tw, tb;
    int   n;
    @(posedge clk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    tb = 1'b0;
    n = 0;
    while (!tb && n < 100) begin
      @(negedge clk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tb = bvalid;
      brsp = bresp;
      @(posedge clk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      n++;
    end
    bready <= 1'b0;
    if (!tb) fail();
  endtask

  // read: result lands in rdat and rrsp
  task automatic rd(input logic [4:0] a);
    logic ta, tr;
    int   n;
    @(posedge clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    tr = 1'b0;
    n = 0;
    while (!tr && n < 100) begin
      @(negedge clk);
      ta = arvalid && arready;
      tr = rvalid;
      rdat = rdata;
      rrsp = rresp;
      @(posedge clk);
      if (ta) arvalid <= 1'b0;
      n++;
    end
    rready <= 1'b0;
    if (!tr) fail();
  endtask

  function automatic int ratio(input logic [1:0] c);
    return (c == 2'h0) ? 2 : ((c == 2'h1) ? 8 : 32);
  endfunction

  // start pulse then wait past a full divide-by-32 conversion
  task automatic stall_conv(input logic [31:0] ctl_end);
    wr(ASC_OFF_CTRL, 32'h60);
    wr(ASC_OFF_CTRL, ctl_end);
    repeat (13 * 32 + 40) @(negedge clk);
    chk(32'(irq), 32'h0);
    rd(ASC_OFF_RESHI);
    chk(rdat, 32'(rows[3].d[8:1]));
  endtask

  // hang guard
  initial begin
    repeat (100000) @(posedge clk);
    fail();
  end

  initial begin
    logic [3:0] ex;
    rows = '{'{2'h0, 2'h0, 9'h1A5}, '{2'h1, 2'h1, 9'h05A},
             '{2'h2, 2'h2, 9'h1FF}, '{2'h3, 2'h1, 9'h100}};
    {rst_b, awvalid, wvalid, bready, arvalid, rready} = '0;
    awaddr = '0;
    araddr = '0;
    wdata = '0;
    wstrb = 4'hF;
    phcfg = 4'hA;
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    // reset state and bus refusals
    chk(32'(cpd), 32'h1);
    chk(32'(in_mode), 32'hF);
    rd(ASC_OFF_CTRL);
    chk(rdat, 32'h80);
    rd(5'h18);
    chk({rdat[29:0], rrsp}, 32'h2);
    wr(5'h18, 32'hFF);
    chk(32'(brsp), 32'h2);
    $display("test reset done");
    // pin modes for every code
    wr(ASC_OFF_DIR, 32'h3);
    for (int p = 0; p < 8; p++) begin
      wr(ASC_OFF_CTRL, 32'(p) << 3);
      @(negedge clk);
      ex = (p >= 4) ? 4'hF : 4'((1 << p) - 1);
      chk(32'(pin_en), 32'(ex));
      chk(32'(ph_en), 32'(phcfg & ~ex));
      chk(32'(in_mode), 32'(ex | 4'h3));
      chk(32'(cpd), 32'(p == 0));
    end
    $display("test pins done");
    // every row gets the full timing and result checks; divide-by-2 is too fast for a real core
    foreach (rows[i]) begin
      wr(ASC_OFF_CLK, 32'(rows[i].div));
      wr(ASC_OFF_IRQ, 32'h7);
      wr(ASC_OFF_CTRL, 32'h60 | 32'(rows[i].ch));
      @(negedge clk);
      chk(32'(cres), 32'h1);
      chk(32'(chan), 32'(rows[i].ch));
      rd(ASC_OFF_CTRL);
      chk(rdat & 32'h80, 32'h80);
      wr(ASC_OFF_CTRL, 32'h20 | 32'(rows[i].ch));
      k = 0;
      while (irq !== 1'b1 && k < 2000) begin
        @(negedge clk);
        k++;
      end
      if (k >= 2000) fail();
      // counting starts at the edge where the sequencer enters conversion, one after the start release lands;
      // the wait ends on the half period after the completion edge
      chk(32'(k), 32'(13 * ratio(rows[i].div) + 1));
      rd(ASC_OFF_RESHI);
      chk(rdat, 32'(rows[i].d[8:1]));
      rd(ASC_OFF_RESLO);
      chk(rdat, {24'h0, rows[i].d[0], 7'h0});
      rd(ASC_OFF_CTRL);
      chk(rdat & 32'h80, 32'h0);
      rd(ASC_OFF_IRQ);
      chk(rdat, 32'h7);
      $display("test conversion %0d done", i);
    end
    // both enables needed, flag still pending
    for (int e = 0; e < 4; e++) begin
      wr(ASC_OFF_IRQ, 32'(e) << 1);
      @(negedge clk);
      chk(32'(irq), 32'(e == 3));
    end
    wr(ASC_OFF_IRQ, 32'h7);
    @(negedge clk);
    chk(32'(irq), 32'h0);
    // channel change without a start pulse leaves busy untouched
    wr(ASC_OFF_CTRL, 32'h20);
    rd(ASC_OFF_CTRL);
    chk(rdat, 32'h20);
    // high result byte is read-only
    wr(ASC_OFF_RESHI, 32'h0);
    rd(ASC_OFF_RESHI);
    chk(rdat, 32'(rows[3].d[8:1]));
    $display("test irq done");
    // abort by clearing pin code while the converter is held in reset
    wr(ASC_OFF_CLK, 32'h2);
    stall_conv(32'h0);
    chk(32'(cpd), 32'h1);
    // reserved divider code never completes
    wr(ASC_OFF_CLK, 32'h3);
    stall_conv(32'h20);
    rd(ASC_OFF_CTRL);
    chk(rdat, 32'hA0);
    // power-off bit in lane one aborts the stalled conversion
    wr(ASC_OFF_CTRL, 32'h120);
    @(negedge clk);
    chk(32'(cpd), 32'h1);
    rd(ASC_OFF_CTRL);
    chk(rdat, 32'h1A0);
    $display("test abort done");
    print_verdict();
  end
endmodule
